// [dv/six_pin_bidirectional_port_tb_top.sv]
`timescale 1ns/10ps
`include "spp_map.svh"
// ==========================================
// Register-level tests of the port
module six_pin_bidirectional_port_tb_top;
    logic        core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        wakeupLatch = 1'b1, extIntEnable = 1'b0, quadBusClk = 1'b0, err;
    logic        resetPinEnable = 1'b0, osc1PinOwned = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [5:0]  pinIn, pinOut, pinOe, pullupOn, extOe = 6'h04, extVal = 6'h04;
    logic [1:0]  oscOption = 2'h0;
    int          mismatches = 0, checks = 0, cyc = 0;

    spp_port u_dut (.core_clk(core_clk), .nrst(nrst), .clkEn(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .pullupOn(pullupOn), .wakeupLatch(wakeupLatch),
        .extIntEnable(extIntEnable), .oscOption(oscOption), .quadBusClk(quadBusClk),
        .resetPinEnable(resetPinEnable), .osc1PinOwned(osc1PinOwned));
    spp_pin_model u_pin (.core_clk(core_clk), .pinOut(pinOut), .pinOe(pinOe),
        .pullupOn(pullupOn), .extOe(extOe), .extVal(extVal), .pinIn(pinIn));

    initial forever #4 core_clk = ~core_clk;

    task automatic print_verdict();
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Hang guard, far above the fewer than a hundred cycles the tests need
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        apb(0, `SPP_OFF_DIR, 0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h0);
        apb(0, `SPP_OFF_PULLUP, 0);
        chk(rd, 32'h0);
        // Latch first so the new driver starts at the right level
        apb(1, `SPP_OFF_DATA, 32'h2a);
        // Bit 2 set on purpose: the input-only pin must still stay undriven
        apb(1, `SPP_OFF_DIR, 32'h3f);
        @(negedge core_clk);
        chk(32'(pinOe), 32'h3b);
        chk(32'(pinOut & pinOe), 32'h2a);
        apb(0, `SPP_OFF_DATA, 0);
        chk(rd, 32'h6e);
        extIntEnable <= 1'b1;
        apb(0, `SPP_OFF_DATA, 0);
        chk(rd, 32'h6a);
        apb(0, `SPP_OFF_CTRL, 0);
        chk(rd, 32'h8);
        extIntEnable <= 1'b0;
        wakeupLatch <= 1'b0;
        extOe <= 6'h3f;
        extVal <= 6'h15;
        apb(1, `SPP_OFF_DIR, 0);
        apb(1, `SPP_OFF_DATA, 32'h3f);
        apb(0, `SPP_OFF_DATA, 0);
        chk(rd, 32'h15);
        apb(1, `SPP_OFF_DIR, 32'h03);
        apb(0, `SPP_OFF_DATA, 0);
        chk(rd, 32'h17);
        extOe <= 6'h00;
        // Bit 6 written high must not be stored
        apb(1, `SPP_OFF_PULLUP, 32'h7f);
        @(negedge core_clk);
        chk(32'(pullupOn), 32'h3c);
        apb(0, `SPP_OFF_PULLUP, 0);
        chk(rd, 32'h3f);
        apb(1, `SPP_OFF_PULLUP, 32'h80);
        @(negedge core_clk);
        chk(32'(pullupOn), 32'h0);
        apb(1, `SPP_OFF_DIR, 32'h10);
        for (int o = 0; o < 4; o++) begin
            @(posedge core_clk);
            oscOption <= 2'(o);
            // Clock low at option 0 and high at option 2, latch bit 4 is high
            quadBusClk <= (o == 2);
            @(negedge core_clk);
            chk(32'({pinOe[4], pinOut[4] & pinOe[4]}),
                (o == 3) ? 0 : (o == 0) ? 2 : 3);
        end
        @(posedge core_clk);
        oscOption <= 2'h0;
        apb(1, `SPP_OFF_PULLUP, 0);
        apb(1, `SPP_OFF_DIR, 32'h3f);
        resetPinEnable <= 1'b1;
        osc1PinOwned <= 1'b1;
        @(negedge core_clk);
        chk(32'(pinOe), 32'h13);
        apb(0, 12'h010, 0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        extOe <= 6'h04;
        extVal <= 6'h00;
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        apb(0, `SPP_OFF_DIR, 0);
        chk(rd, 32'h0);
        apb(1, `SPP_OFF_DIR, 32'h3b);
        apb(0, `SPP_OFF_DATA, 0);
        chk(rd, 32'h3b);
        print_verdict();
    end
endmodule

// [dv/spp_pin_model.sv]
`timescale 1ns/10ps
// ==========================================
// Board side of the six pins
module spp_pin_model (
    input  wire logic       core_clk, // Bus clock
    input  wire logic [5:0] pinOut,   // Port drive value
    input  wire logic [5:0] pinOe,    // Port drives pin
    input  wire logic [5:0] pullupOn, // Pull-up connected
    input  wire logic [5:0] extOe,    // Board drives pin
    input  wire logic [5:0] extVal,   // Board drive value
    output logic      [5:0] pinIn     // Resolved level
);
    logic [5:0] flt = 6'h15;
    // Floating pins toggle so a stale read never matches by luck
    always @(posedge core_clk) flt <= ~flt;
    always_comb pinIn = (pinOe & pinOut) | (~pinOe & extOe & extVal)
        | (~pinOe & ~extOe & (pullupOn | flt));
endmodule

// [dv/spp_port_checker.sv]
`timescale 1ns/10ps
`include "spp_map.svh"
// ==========================================
// Port-level properties
module spp_port_checker (
    input wire logic        core_clk,       // Bus clock
    input wire logic        nrst,           // Sync reset
    input wire logic        pwrite,         // APB direction
    input wire logic [11:0] paddr,          // APB address
    input wire logic [31:0] pwdata,         // APB write data
    input wire logic [3:0]  pstrb,          // APB strobes
    input wire logic [31:0] prdata,         // APB read data
    input wire logic        pready,         // APB ready
    input wire logic [5:0]  pinIn,          // Pin levels
    input wire logic [5:0]  pinOe,          // Pin enables
    input wire logic [5:0]  pullupOn,       // Pull-ups
    input wire logic        wakeupLatch,    // Wakeup latch
    input wire logic        extIntEnable,   // Interrupt owns pin 2
    input wire logic [1:0]  oscOption,      // Oscillator option
    input wire logic        resetPinEnable, // Reset owns pin 3
    input wire logic        osc1PinOwned    // Oscillator owns pin 5
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic rdData;
    assign rdData = pready && !pwrite && paddr == `SPP_OFF_DATA;
    AST_DIR_RST: assert property ($rose(nrst) |-> pinOe == 6'h00)
        else $error("Pins driven after reset");
    AST_WR_DIR: assert property (pready && pwrite && paddr == `SPP_OFF_DIR && pstrb[0]
        |=> pinOe[1:0] == $past(pwdata[1:0])) else $error("Direction write not applied");
    AST_INONLY: assert property (!pinOe[2])
        else $error("Input-only pin driven");
    AST_PULL_OUT: assert property ((pinOe & pullupOn) == 6'h00)
        else $error("Pull-up on a driven pin");
    AST_RD_WAKE: assert property (rdData |-> prdata[7:6] == {1'b0, wakeupLatch})
        else $error("Wakeup bit read wrong");
    AST_RD_PIN2: assert property (
        rdData |-> prdata[2] == (!extIntEnable && pinIn[2])) else $error("Bit 2 read wrong");
    AST_XTAL: assert property (oscOption == 2'h3 |-> !pinOe[4] && !pullupOn[4])
        else $error("Pin 4 used under crystal option");
    AST_OWN3: assert property (resetPinEnable |-> !pinOe[3] && !pullupOn[3])
        else $error("Pin 3 not released to reset");
    AST_OWN5: assert property (
        osc1PinOwned || oscOption != 2'h0 |-> !pinOe[5] && !pullupOn[5])
        else $error("Pin 5 not released to oscillator");
    AST_OWN2: assert property (extIntEnable |-> !pullupOn[2])
        else $error("Pin 2 pull-up while interrupt owns it");
endmodule

bind spp_port spp_port_checker u_chk (.core_clk(core_clk), .nrst(nrst), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pinIn(pinIn), .pinOe(pinOe), .pullupOn(pullupOn), .wakeupLatch(wakeupLatch),
    .extIntEnable(extIntEnable), .oscOption(oscOption), .resetPinEnable(resetPinEnable),
    .osc1PinOwned(osc1PinOwned));

// [include/spp_map.svh]
`ifndef SPP_MAP_SVH
`define SPP_MAP_SVH

// Byte offsets on the register bus
`define SPP_OFF_DATA      12'h000
`define SPP_OFF_DIR       12'h004
`define SPP_OFF_PULLUP    12'h008
`define SPP_OFF_CTRL      12'h00c

// Field positions
`define SPP_PIN_COUNT     6
`define SPP_INONLY_BIT    2
`define SPP_XOUT_BIT      4
`define SPP_WAKE_BIT      6
`define SPP_XOUT_EN_BIT   7

// Reset values
`define SPP_DIR_RST       6'h00
`define SPP_PULLUP_RST    6'h00
`define SPP_XOUT_EN_RST   1'b0

`endif

// [include/spp_pin_if.sv]
`timescale 1ns/10ps
interface spp_pin_if;
    logic latchBit;
    logic dirBit;
    logic pullBit;
    logic pinIn;
    logic ownOverride;
    logic ownOut;
    logic ownOe;
    logic pinOut;
    logic pinOe;
    logic pullOn;
    logic readBit;

    modport port (input latchBit, dirBit, pullBit, pinIn, ownOverride, ownOut, ownOe,
                  output pinOut, pinOe, pullOn, readBit);
    modport top  (output latchBit, dirBit, pullBit, pinIn, ownOverride, ownOut, ownOe,
                  input pinOut, pinOe, pullOn, readBit);
endinterface

// [include/spp_pkg.sv]
package spp_pkg;
    typedef enum logic [1:0] {
        SPP_OSC_INTERNAL,
        SPP_OSC_EXTCLK,
        SPP_OSC_RC,
        SPP_OSC_XTAL
    } spp_osc_opt_t;

    typedef enum {
        SPP_IDLE,
        SPP_ACCESS
    } spp_bus_state_t;
endpackage

// [rtl/spp_apb_slave.sv]
`timescale 1ns/10ps
`include "spp_map.svh"
module spp_apb_slave (
    input  wire logic        core_clk,   // Bus clock
    input  wire logic        nrst,       // Sync reset, active low
    input  wire logic        clkEn,      // Freezes state when low
    input  wire logic        psel,       // APB select
    input  wire logic        penable,    // APB enable
    input  wire logic        pwrite,     // APB direction
    input  wire logic [11:0] paddr,      // APB byte address
    output logic             pready,     // APB ready
    output logic             pslverr,    // Unmapped address
    output logic             wrStb,      // Write strobe, one cycle
    output logic             rdStb,      // Read strobe, one cycle
    output logic             hit         // Address maps to a register
);
    spp_pkg::spp_bus_state_t state_reg, state_next;

    always_comb begin
        hit = (paddr == `SPP_OFF_DATA) || (paddr == `SPP_OFF_DIR)
           || (paddr == `SPP_OFF_PULLUP) || (paddr == `SPP_OFF_CTRL);
        pready  = psel && penable && clkEn;
        pslverr = pready && !hit;
        wrStb   = pready && pwrite && hit;
        rdStb   = pready && !pwrite;
        case (state_reg)
            spp_pkg::SPP_IDLE:   state_next = (psel && !penable) ? spp_pkg::SPP_ACCESS
                                                                 : spp_pkg::SPP_IDLE;
            spp_pkg::SPP_ACCESS: state_next = pready ? spp_pkg::SPP_IDLE : spp_pkg::SPP_ACCESS;
            default:             state_next = spp_pkg::SPP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_reg <= spp_pkg::SPP_IDLE;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end
endmodule

// [rtl/spp_pin_cell.sv]
`timescale 1ns/10ps
module spp_pin_cell #(
    parameter bit INPUT_ONLY = 1'b0
) (
    spp_pin_if.port pin     // One port pin
);
    logic gpioOut;

    always_comb begin
        gpioOut = pin.dirBit && !INPUT_ONLY;                    // [RULE2] [RULE16]
        if (pin.ownOverride) begin
            pin.pinOe  = pin.ownOe;                             // [RULE17]
            pin.pinOut = pin.ownOut;
            pin.pullOn = 1'b0;
        end else begin
            pin.pinOe  = gpioOut;
            pin.pinOut = pin.latchBit;
            pin.pullOn = pin.pullBit && !pin.dirBit;            // [RULE7] [RULE8] [RULE9]
        end
        // Output direction reads latch, input reads pin
        pin.readBit = gpioOut ? pin.latchBit : pin.pinIn;       // [RULE4] [RULE5]
    end
endmodule

// [rtl/spp_port.sv]
//Behaviour
//RULE1: Six-bit data latch, one bit per pin, untouched by reset.
//RULE2: Direction bit 1 enables the pin driver, 0 disables it.
//RULE3: Reset clears all six direction bits; pins start as inputs.
//RULE4: Direction 1: data read returns the latched value.
//RULE5: Direction 0: data read returns the sampled pin level.
//RULE6: Data writes always update the latch, whatever the direction.
//RULE7: Pull-up on only when pull-up enable is 1 and direction is 0.
//RULE8: Output direction disconnects the pull-up at once.
//RULE9: Pull-up enable 0 keeps the pull-up off.
//RULE10: Bit 2 reads 0 while the external interrupt owns it.
//RULE11: Bit 2 reads the pin level when the external interrupt is off.
//RULE12: Data register bit 6 mirrors the wakeup request latch, read only.
//RULE13: No seventh pin; no direction or pull-up bit for bit 6.
//RULE14: Internal/RC option with enable 1 drives quad bus clock on pin 4.
//RULE15: Crystal output enable ignored with crystal or external clock option.
//RULE16: Input-only pin 2 never gets a driver.
//RULE17: Shared function owning a pin overrides port driver and direction.
//RULE18: Software writes the latch before turning a pin to output.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "spp_map.svh"
module spp_port (
    input  wire logic        core_clk,       // Bus clock, 125 MHz
    input  wire logic        nrst,           // Sync reset, active low
    input  wire logic        clkEn,          // Freezes all state when low
    input  wire logic        psel,           // APB select
    input  wire logic        penable,        // APB enable
    input  wire logic        pwrite,         // APB direction
    input  wire logic [11:0] paddr,          // APB byte address
    input  wire logic [31:0] pwdata,         // APB write data
    input  wire logic [3:0]  pstrb,          // APB byte strobes
    output logic      [31:0] prdata,         // APB read data
    output logic             pready,         // APB ready
    output logic             pslverr,        // APB error on unmapped address
    input  wire logic [5:0]  pinIn,          // Pin levels, synchronous
    output logic      [5:0]  pinOut,         // Pin output values
    output logic      [5:0]  pinOe,          // Pin output enables
    output logic      [5:0]  pullupOn,       // Pull-up connect per pin
    input  wire logic        wakeupLatch,    // Wakeup request latch
    input  wire logic        extIntEnable,   // External interrupt owns pin 2
    input  wire logic [1:0]  oscOption,      // Oscillator option
    input  wire logic        quadBusClk,     // Quad bus clock
    input  wire logic        resetPinEnable, // Reset function owns pin 3
    input  wire logic        osc1PinOwned    // Oscillator input owns pin 5
);
    // ==========================================================
    // Register state
    // ==========================================================
    logic [5:0]  dataLatch_reg, dataLatch_next;
    logic [5:0]  dir_reg, dir_next;
    logic [5:0]  pullEn_reg, pullEn_next;
    logic        xoutEn_reg, xoutEn_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        wrStb, rdStb, hit;
    logic [5:0]  readBits;
    logic [5:0]  ownOverride, ownOut, ownOe;
    logic        xtalOpt, clkOutActive;
    logic [7:0]  dataView;

    spp_apb_slave u_bus (
        .core_clk (core_clk),
        .nrst     (nrst),
        .clkEn    (clkEn),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pready   (pready),
        .pslverr  (pslverr),
        .wrStb    (wrStb),
        .rdStb    (rdStb),
        .hit      (hit)
    );

    // ==========================================================
    // Shared pin ownership
    // ==========================================================
    always_comb begin
        xtalOpt = (oscOption == spp_pkg::SPP_OSC_XTAL);
        // Enable is honoured only for internal or RC clocking
        clkOutActive = xoutEn_reg && ((oscOption == spp_pkg::SPP_OSC_INTERNAL)
                                   || (oscOption == spp_pkg::SPP_OSC_RC));   // [RULE14] [RULE15]
        ownOverride = 6'h00;
        ownOut      = 6'h00;
        ownOe       = 6'h00;
        ownOverride[`SPP_XOUT_BIT] = clkOutActive || xtalOpt;                // [RULE17]
        ownOut[`SPP_XOUT_BIT]      = clkOutActive ? quadBusClk : 1'b0;       // [RULE14]
        // Crystal amplifier drives this pin outside the port
        ownOe[`SPP_XOUT_BIT]       = clkOutActive;                           // [RULE15]
        ownOverride[3] = resetPinEnable;                                      // [RULE17]
        ownOverride[5] = osc1PinOwned || xtalOpt
                      || (oscOption == spp_pkg::SPP_OSC_EXTCLK)
                      || (oscOption == spp_pkg::SPP_OSC_RC);                 // [RULE17]
        ownOverride[`SPP_INONLY_BIT] = extIntEnable;                          // [RULE17]
    end

    // ==========================================================
    // Pin cells
    // ==========================================================
    genvar gi;
    generate
        for (gi = 0; gi < `SPP_PIN_COUNT; gi++) begin : g_pin
            spp_pin_if pif ();
            assign pif.latchBit    = dataLatch_reg[gi];
            assign pif.dirBit      = dir_reg[gi];
            assign pif.pullBit     = pullEn_reg[gi];
            assign pif.pinIn       = pinIn[gi];
            assign pif.ownOverride = ownOverride[gi];
            assign pif.ownOut      = ownOut[gi];
            assign pif.ownOe       = ownOe[gi];
            spp_pin_cell #(
                .INPUT_ONLY (gi == `SPP_INONLY_BIT)
            ) u_cell (
                .pin (pif.port)
            );
            assign pinOut[gi]   = pif.pinOut;
            assign pinOe[gi]    = pif.pinOe;
            assign pullupOn[gi] = pif.pullOn;
            assign readBits[gi] = pif.readBit;
        end
    endgenerate

    // ==========================================================
    // Register file
    // ==========================================================
    always_comb begin
        dataView = {1'b0, wakeupLatch, readBits};                             // [RULE12]
        // Interrupt owns pin 2: read as zero, else real level
        dataView[`SPP_INONLY_BIT] = extIntEnable ? 1'b0
                                                 : pinIn[`SPP_INONLY_BIT];    // [RULE10] [RULE11]
        dataLatch_next = dataLatch_reg;
        dir_next       = dir_reg;
        pullEn_next    = pullEn_reg;
        xoutEn_next    = xoutEn_reg;
        prdata_next    = prdata_reg;
        if (wrStb && pstrb[0]) begin
            case (paddr)
                `SPP_OFF_DATA:   dataLatch_next = pwdata[5:0];                // [RULE6] [RULE13]
                `SPP_OFF_DIR:    dir_next       = pwdata[5:0];                // [RULE2] [RULE13]
                `SPP_OFF_PULLUP: begin
                    pullEn_next = pwdata[5:0];
                    xoutEn_next = pwdata[`SPP_XOUT_EN_BIT];
                end
                default:         dataLatch_next = dataLatch_reg;
            endcase
        end
        if (rdStb) begin
            case (paddr)
                `SPP_OFF_DATA:   prdata_next = {24'h000000, dataView};        // [RULE4] [RULE5]
                `SPP_OFF_DIR:    prdata_next = {26'h0000000, dir_reg};
                `SPP_OFF_PULLUP: prdata_next = {24'h000000, xoutEn_reg, 1'b0, pullEn_reg};
                `SPP_OFF_CTRL:   prdata_next = {28'h0000000, extIntEnable, 1'b0, oscOption};
                default:         prdata_next = 32'h00000000;
            endcase
        end
    end

    // Read data must be valid in the pready cycle, so drive it combinationally
    always_comb begin
        prdata = 32'h00000000;
        if (rdStb && hit) begin
            prdata = prdata_next;
        end
    end

    // Latch has no reset: its contents survive system reset
    always_ff @(posedge core_clk) begin
        if (clkEn) begin
            dataLatch_reg <= dataLatch_next;                                  // [RULE1]
            prdata_reg    <= prdata_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            dir_reg    <= `SPP_DIR_RST;                                       // [RULE3]
            pullEn_reg <= `SPP_PULLUP_RST;
            xoutEn_reg <= `SPP_XOUT_EN_RST;
        end else if (clkEn) begin
            dir_reg    <= dir_next;
            pullEn_reg <= pullEn_next;
            xoutEn_reg <= xoutEn_next;
        end
    end
endmodule
